// ---- output_divider_delay_config.sv ----
// Register bank holding the divider, delay and driver configuration of one clock output.
// Notes on behaviour
// RQ1 - Divider bits 19:16, 15:8, 7:0 from three registers.
// RQ2 - Divider bits 29:28 from top bits of 57h.
// RQ3 - Phase select routes true or complement to pins.
// RQ4 - Software should program single-ended strength to seven.
// RQ5 - Coarse delay counts zero to 63 VCO periods.
// RQ6 - Two-bit fine delay adds zero to three steps.
// RQ7 - Extra bit in 57h extends fine delay to four.
// RQ8 - Three-bit code selects the output driver standard.
// RQ9 - Software declares supply level as 1.8/2.5/3.3 V.
// RQ10 - All fields read back and reset to zero.
`timescale 1ns/1ns
module output_divider_delay_config (
	input  wire logic                                  ref_clk,
	input  wire logic                                  reset,
	input  wire logic                                  clk_en,
	input  wire output_divider_delay_pkg::reg_req_t    reg_req,
	output      output_divider_delay_pkg::reg_rsp_t    reg_rsp,
	output      output_divider_delay_pkg::output_cfg_t output_cfg
);

	typedef enum {
		REG_HIGH_NIBBLE,
		REG_MID_BYTE,
		REG_LOW_BYTE,
		REG_PHASE_STRENGTH,
		REG_OUTPUT_DELAY,
		REG_DRIVER_STANDARD,
		REG_TOP_FINE,
		REG_COUNT
	} reg_index_t;

	logic [7:0] regs_q [REG_COUNT];
	logic [7:0] regs_d [REG_COUNT];
	output_divider_delay_pkg::reg_rsp_t    rsp_q;
	output_divider_delay_pkg::reg_rsp_t    rsp_d;
	output_divider_delay_pkg::output_cfg_t cfg_q;
	output_divider_delay_pkg::output_cfg_t cfg_d;
	// One decoded index serves the write and the read path alike.
	int                                    req_index;
	logic                                  wr_hit;
	logic                                  rd_hit;

	// Address decode is used by both the write and the read path.
	function automatic int decode_index(input logic [7:0] addr);
		if (addr == output_divider_delay_pkg::ADDR_DIV_HIGH_NIBBLE) begin
			return REG_HIGH_NIBBLE;
		end else if (addr == output_divider_delay_pkg::ADDR_DIV_MID_BYTE) begin
			return REG_MID_BYTE;
		end else if (addr == output_divider_delay_pkg::ADDR_DIV_LOW_BYTE) begin
			return REG_LOW_BYTE;
		end else if (addr == output_divider_delay_pkg::ADDR_PHASE_STRENGTH) begin
			return REG_PHASE_STRENGTH;
		end else if (addr == output_divider_delay_pkg::ADDR_OUTPUT_DELAY) begin
			return REG_OUTPUT_DELAY;
		end else if (addr == output_divider_delay_pkg::ADDR_DRIVER_STANDARD) begin
			return REG_DRIVER_STANDARD;
		end else if (addr == output_divider_delay_pkg::ADDR_DIV_TOP_FINE) begin
			return REG_TOP_FINE;
		end else begin
			return REG_COUNT;
		end
	endfunction

	// Bits with no documented meaning are not stored, so they always read back as zero.
	function automatic logic [7:0] field_mask(input int idx);
		case (idx)
			REG_HIGH_NIBBLE:     return output_divider_delay_pkg::MASK_DIV_HIGH_NIBBLE;
			REG_PHASE_STRENGTH:  return output_divider_delay_pkg::MASK_PHASE_STRENGTH;
			REG_DRIVER_STANDARD: return output_divider_delay_pkg::MASK_DRIVER_STANDARD;
			REG_TOP_FINE:        return output_divider_delay_pkg::MASK_DIV_TOP_FINE;
			default:             return output_divider_delay_pkg::MASK_FULL_BYTE;
		endcase
	endfunction

	// Writes to an address outside the map are dropped, so they can never disturb a stored field.
	always_comb begin
		int idx;
		idx = decode_index(reg_req.addr);
		req_index = idx;
		wr_hit = reg_req.wr_en && (idx != REG_COUNT);
		rd_hit = reg_req.rd_en && (idx != REG_COUNT);
	end

	always_comb begin
		for (int i = 0; i < REG_COUNT; i++) begin
			regs_d[i] = regs_q[i];
		end
		if (wr_hit) begin
			regs_d[req_index] = reg_req.wr_data & field_mask(req_index); // [RQ10]
		end
	end

	// The read takes the stored byte before this cycle's write, so a same-cycle write does not leak through.
	always_comb begin
		rsp_d.rd_valid = reg_req.rd_en;
		if (rd_hit) begin
			rsp_d.rd_data = regs_q[req_index]; // [RQ10]
		end else if (reg_req.rd_en) begin
			rsp_d.rd_data = output_divider_delay_pkg::READ_UNMAPPED;
		end else begin
			rsp_d.rd_data = rsp_q.rd_data;
		end
	end

	// Divider bits with no source register stay zero, so no stale high bits can reach the divider.
	function automatic logic [29:0] assemble_divider(
		input logic [7:0] top_byte,
		input logic [7:0] nibble_byte,
		input logic [7:0] mid_byte,
		input logic [7:0] low_byte
	);
		logic [29:0] value;
		value = '0;
		value[output_divider_delay_pkg::DIV_TOP_MSB:output_divider_delay_pkg::DIV_TOP_LSB] =
			top_byte[output_divider_delay_pkg::TOP_FIELD_MSB:output_divider_delay_pkg::TOP_FIELD_LSB]; // [RQ2]
		value[output_divider_delay_pkg::DIV_NIBBLE_MSB:output_divider_delay_pkg::DIV_NIBBLE_LSB] =
			nibble_byte[output_divider_delay_pkg::NIBBLE_FIELD_MSB:output_divider_delay_pkg::NIBBLE_FIELD_LSB]; // [RQ1]
		value[output_divider_delay_pkg::DIV_MID_MSB:output_divider_delay_pkg::DIV_MID_LSB] = mid_byte; // [RQ1]
		value[output_divider_delay_pkg::DIV_LOW_MSB:output_divider_delay_pkg::DIV_LOW_LSB] = low_byte; // [RQ1]
		return value;
	endfunction

	// Codes above four have no step count of their own, so they saturate at the longest delay.
	function automatic logic [2:0] saturate_fine(
		input logic       ext_bit,
		input logic [1:0] base_code
	);
		logic [2:0] code;
		code = {ext_bit, base_code};
		if (code > output_divider_delay_pkg::FINE_STEPS_MAX) begin
			return output_divider_delay_pkg::FINE_STEPS_MAX; // [RQ7]
		end else begin
			return code; // [RQ6]
		end
	endfunction

	// Bit one of the result feeds the P pin and bit zero the N pin.
	function automatic logic [1:0] route_phase(input logic [1:0] sel);
		logic [1:0] sources;
		case (sel)
			output_divider_delay_pkg::PHASE_TRUE_COMP: begin
				sources = {output_divider_delay_pkg::SOURCE_TRUE, output_divider_delay_pkg::SOURCE_COMP}; // [RQ3]
			end
			output_divider_delay_pkg::PHASE_TRUE_BOTH: begin
				sources = {output_divider_delay_pkg::SOURCE_TRUE, output_divider_delay_pkg::SOURCE_TRUE}; // [RQ3]
			end
			default: begin
				sources = {output_divider_delay_pkg::SOURCE_COMP, output_divider_delay_pkg::SOURCE_COMP}; // [RQ3]
			end
		endcase
		return sources;
	endfunction

	// Outputs follow the next register values, so a write shows on the outputs at the same edge that stores it.
	always_comb begin
		logic [1:0] pin_sources;
		pin_sources = route_phase(
			regs_d[REG_PHASE_STRENGTH][output_divider_delay_pkg::PHASE_SEL_MSB:output_divider_delay_pkg::PHASE_SEL_LSB]);
		cfg_d.output_divider = assemble_divider( // [RQ1] [RQ2]
			regs_d[REG_TOP_FINE],
			regs_d[REG_HIGH_NIBBLE],
			regs_d[REG_MID_BYTE],
			regs_d[REG_LOW_BYTE]);
		cfg_d.coarse_delay = // [RQ5]
			regs_d[REG_OUTPUT_DELAY][output_divider_delay_pkg::COARSE_MSB:output_divider_delay_pkg::COARSE_LSB];
		cfg_d.fine_delay_steps = saturate_fine( // [RQ6] [RQ7]
			regs_d[REG_TOP_FINE][output_divider_delay_pkg::FINE_EXT_BIT],
			regs_d[REG_OUTPUT_DELAY][output_divider_delay_pkg::FINE_BASE_MSB:output_divider_delay_pkg::FINE_BASE_LSB]);
		cfg_d.out_pin_p_source = pin_sources[1]; // [RQ3]
		cfg_d.out_pin_n_source = pin_sources[0]; // [RQ3]
		// Strength is passed through as written; choosing seven is left to software.
		cfg_d.drive_strength =
			regs_d[REG_PHASE_STRENGTH][output_divider_delay_pkg::STRENGTH_MSB:output_divider_delay_pkg::STRENGTH_LSB];
		cfg_d.driver_standard = // [RQ8]
			regs_d[REG_DRIVER_STANDARD][output_divider_delay_pkg::DRV_STD_MSB:output_divider_delay_pkg::DRV_STD_LSB];
		// The supply bits share the delay byte with the coarse delay, so both follow one stored byte.
		cfg_d.supply_level_select = // [RQ9]
			regs_d[REG_OUTPUT_DELAY][output_divider_delay_pkg::SUPPLY_MSB:output_divider_delay_pkg::SUPPLY_LSB];
	end

	// Stored register bytes.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_q[i] <= output_divider_delay_pkg::RESET_VALUE; // [RQ10]
			end
		end else if (clk_en) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_q[i] <= regs_d[i];
			end
		end
	end

	// Read response; it freezes with the clock enable, so a pulse can last longer while enable is low.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rsp_q <= '0;
		end else if (clk_en) begin
			rsp_q <= rsp_d;
		end
	end

	// Registered configuration outputs.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cfg_q <= '0;
		end else if (clk_en) begin
			cfg_q <= cfg_d;
		end
	end

	assign reg_rsp = rsp_q;
	assign output_cfg = cfg_q;

endmodule // output_divider_delay_config

// ---- output_divider_delay_pkg.sv ----
// Package with the register map, field layout and carrier types of the output configuration bank.
package output_divider_delay_pkg;

	localparam logic [7:0] ADDR_DIV_HIGH_NIBBLE = 8'h50;
	localparam logic [7:0] ADDR_DIV_MID_BYTE    = 8'h51;
	localparam logic [7:0] ADDR_DIV_LOW_BYTE    = 8'h52;
	localparam logic [7:0] ADDR_PHASE_STRENGTH  = 8'h53;
	localparam logic [7:0] ADDR_OUTPUT_DELAY    = 8'h54;
	localparam logic [7:0] ADDR_DRIVER_STANDARD = 8'h55;
	localparam logic [7:0] ADDR_DIV_TOP_FINE    = 8'h57;

	localparam logic [7:0] MASK_DIV_HIGH_NIBBLE = 8'h0F;
	localparam logic [7:0] MASK_FULL_BYTE       = 8'hFF;
	localparam logic [7:0] MASK_PHASE_STRENGTH  = 8'hC7;
	localparam logic [7:0] MASK_DRIVER_STANDARD = 8'h07;
	localparam logic [7:0] MASK_DIV_TOP_FINE    = 8'hD0;

	localparam logic [7:0] RESET_VALUE          = 8'h00;
	localparam logic [7:0] READ_UNMAPPED        = 8'h00;

	localparam logic [2:0] FINE_STEPS_MAX       = 3'h4;
	localparam int         FINE_STEP_PS         = 30;

	// Bit positions inside the assembled divider value.
	localparam int         DIV_TOP_MSB          = 29;
	localparam int         DIV_TOP_LSB          = 28;
	localparam int         DIV_NIBBLE_MSB       = 19;
	localparam int         DIV_NIBBLE_LSB       = 16;
	localparam int         DIV_MID_MSB          = 15;
	localparam int         DIV_MID_LSB          = 8;
	localparam int         DIV_LOW_MSB          = 7;
	localparam int         DIV_LOW_LSB          = 0;

	// Bit positions of the fields inside their registers.
	localparam int         TOP_FIELD_MSB        = 7;
	localparam int         TOP_FIELD_LSB        = 6;
	localparam int         NIBBLE_FIELD_MSB     = 3;
	localparam int         NIBBLE_FIELD_LSB     = 0;
	localparam int         FINE_EXT_BIT         = 4;
	localparam int         FINE_BASE_MSB        = 7;
	localparam int         FINE_BASE_LSB        = 6;
	localparam int         COARSE_MSB           = 5;
	localparam int         COARSE_LSB           = 0;
	localparam int         SUPPLY_MSB           = 4;
	localparam int         SUPPLY_LSB           = 3;
	localparam int         PHASE_SEL_MSB        = 7;
	localparam int         PHASE_SEL_LSB        = 6;
	localparam int         STRENGTH_MSB         = 2;
	localparam int         STRENGTH_LSB         = 0;
	localparam int         DRV_STD_MSB          = 2;
	localparam int         DRV_STD_LSB          = 0;

	// Phase selection codes and pin source encodings.
	localparam logic [1:0] PHASE_TRUE_COMP      = 2'h0;
	localparam logic [1:0] PHASE_TRUE_BOTH      = 2'h1;
	localparam logic       SOURCE_TRUE          = 1'h0;
	localparam logic       SOURCE_COMP          = 1'h1;

	typedef enum logic [2:0] {
		DRV_LVDS         = 3'h0,
		DRV_LVPECL_CM    = 3'h1,
		DRV_CML          = 3'h2,
		DRV_HCSL         = 3'h3,
		DRV_LVDS_BOOST   = 3'h4,
		DRV_LVPECL_NO_CM = 3'h5
	} driver_standard_t;

	typedef enum logic [1:0] {
		SUPPLY_1V8 = 2'h0,
		SUPPLY_2V5 = 2'h1,
		SUPPLY_3V3 = 2'h2
	} supply_level_t;

	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wr_data;
	} reg_req_t;

	typedef struct packed {
		logic       rd_valid;
		logic [7:0] rd_data;
	} reg_rsp_t;

	typedef struct packed {
		logic [29:0] output_divider;
		logic [5:0]  coarse_delay;
		logic [2:0]  fine_delay_steps;
		logic        out_pin_p_source;
		logic        out_pin_n_source;
		logic [2:0]  drive_strength;
		logic [2:0]  driver_standard;
		logic [1:0]  supply_level_select;
	} output_cfg_t;

endpackage

// ---- output_divider_delay_checker.sv ----
// Checker for the output configuration bank ports.
`timescale 1ns/1ns
module output_divider_delay_checker (
	input wire logic                                  ref_clk,
	input wire logic                                  reset,
	input wire logic                                  clk_en,
	input wire output_divider_delay_pkg::reg_req_t    reg_req,
	input wire output_divider_delay_pkg::reg_rsp_t    reg_rsp,
	input wire output_divider_delay_pkg::output_cfg_t output_cfg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_wr(logic [7:0] a);
		clk_en && reg_req.wr_en && reg_req.addr == a;
	endsequence
	a_read_valid: assert property (clk_en && reg_req.rd_en |=> reg_rsp.rd_valid) else $error("no valid");
	a_mid_byte: assert property (s_wr(8'h51) |=> output_cfg.output_divider[15:8] == $past(reg_req.wr_data)) else $error("mid");
	a_low_byte: assert property (s_wr(8'h52) |=> output_cfg.output_divider[7:0] == $past(reg_req.wr_data)) else $error("low");
	a_top_bits: assert property (s_wr(8'h57) |=> output_cfg.output_divider[29:28] == $past(reg_req.wr_data[7:6])) else $error("top");
	a_phase_route: assert property (s_wr(8'h53) |=> output_cfg.out_pin_p_source == $past(reg_req.wr_data[7])
		&& output_cfg.out_pin_n_source == ($past(reg_req.wr_data[7:6]) != 2'h1)) else $error("phase");
	a_coarse_delay: assert property (s_wr(8'h54) |=> output_cfg.coarse_delay == $past(reg_req.wr_data[5:0])) else $error("coarse");
	a_fine_bound: assert property (output_cfg.fine_delay_steps <= 3'h4) else $error("fine");
	a_driver_code: assert property (s_wr(8'h55) |=> output_cfg.driver_standard == $past(reg_req.wr_data[2:0])) else $error("drv");
endmodule // output_divider_delay_checker
bind output_divider_delay_config output_divider_delay_checker u_output_divider_delay_checker (.ref_clk, .reset,
	.clk_en, .reg_req, .reg_rsp, .output_cfg);

// ---- tb_top.sv ----
// Randomised self-checking bench for the output configuration bank.
`timescale 1ns/1ns
module tb_top;
	logic ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
	output_divider_delay_pkg::reg_req_t reg_req = '0;
	output_divider_delay_pkg::reg_rsp_t reg_rsp;
	output_divider_delay_pkg::output_cfg_t output_cfg;
	logic [7:0] m [256] = '{default: 8'h00};
	int fail_count = 0, tests_run = 0;
	logic [7:0] last_rd = 8'h00;
	output_divider_delay_config u_output_divider_delay_config (.ref_clk, .reset, .clk_en, .reg_req, .reg_rsp,
		.output_cfg);
	initial forever #2 ref_clk = ~ref_clk;
	function automatic logic [7:0] msk(logic [7:0] a);
		case (a)
			8'h50: return 8'h0F;
			8'h51, 8'h52, 8'h54: return 8'hFF;
			8'h53: return 8'hC7;
			8'h55: return 8'h07;
			8'h57: return 8'hD0;
			default: return 8'h00;
		endcase
	endfunction
	function automatic output_divider_delay_pkg::output_cfg_t exp_cfg();
		output_divider_delay_pkg::output_cfg_t e;
		logic [2:0] f;
		f = {m[8'h57][4], m[8'h54][7:6]};
		e.output_divider = {m[8'h57][7:6], 8'h00, m[8'h50][3:0], m[8'h51], m[8'h52]};
		e.coarse_delay = m[8'h54][5:0];
		e.fine_delay_steps = (f > 3'h4) ? 3'h4 : f;
		e.out_pin_p_source = m[8'h53][7];
		e.out_pin_n_source = m[8'h53][7:6] != 2'h1;
		e.drive_strength = m[8'h53][2:0];
		e.driver_standard = m[8'h55][2:0];
		e.supply_level_select = m[8'h54][4:3];
		return e;
	endfunction
	task automatic chk(string n, logic [48:0] e, logic [48:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// A read in the same cycle as a write to its address must still see the old byte.
	task automatic acc(logic w, logic r, logic [7:0] a, logic [7:0] d, logic e);
		logic [7:0] x;
		x = m[a];
		@(negedge ref_clk);
		clk_en = e;
		reg_req = {w, r, a, d};
		if (w && e) m[a] = d & msk(a);
		@(negedge ref_clk);
		clk_en = 1'b1;
		reg_req = '0;
		chk("rd_valid", 49'(r && e), 49'(reg_rsp.rd_valid));
		if (r && e) last_rd = x;
		chk("rd_data", 49'(last_rd), 49'(reg_rsp.rd_data));
		chk("output_cfg", exp_cfg(), output_cfg);
	endtask
	task automatic report_and_stop();
		if (fail_count == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(37322));
		repeat (12) @(negedge ref_clk);
		reset = 1'b0;
		for (int a = 8'h4E; a < 8'h59; a++) acc(1'b0, 1'b1, 8'(a), 8'h00, 1'b1);
		for (int i = 0; i < 8; i++) begin
			acc(1'b1, 1'b1, 8'h53, {i[1:0], 6'h07}, 1'b1);
			acc(1'b1, 1'b0, 8'h54, {i[1:0], 1'b0, i[1:0], 3'h5}, 1'b1);
			acc(1'b1, 1'b0, 8'h55, 8'(i), 1'b1);
			acc(1'b1, 1'b1, 8'h57, {i[1:0], 1'b0, i[2], 4'hF}, 1'b1);
		end
		repeat (400) acc(1'($urandom), 1'($urandom), 8'h4E + 8'($urandom % 11), 8'($urandom), $urandom % 6 != 0);
		report_and_stop();
	end
	initial begin
		#20000;
		fail_count++;
		report_and_stop();
	end
endmodule // tb_top
